// >>> design/flp_pkg.sv
// constants and carrier types for the flash command, autoselect and protection logic
package flp_pkg;
    // ====================================================================
    // widths
    localparam int AW   = 19;
    localparam int DW   = 16;
    localparam int NSEC = 9;

    // ====================================================================
    // command register codes and unlock addresses
    localparam logic [10:0] UL1_ADDR    = 11'h555;
    localparam logic [10:0] UL2_ADDR    = 11'h2aa;
    localparam logic [7:0]  CMD_UL1     = 8'haa;
    localparam logic [7:0]  CMD_UL2     = 8'h55;
    localparam logic [7:0]  CMD_ASEL    = 8'h90;
    localparam logic [7:0]  CMD_PROG    = 8'ha0;
    localparam logic [7:0]  CMD_ERASE   = 8'h80;
    localparam logic [7:0]  CMD_SEC_ER  = 8'h30;
    localparam logic [7:0]  CMD_CHIP_ER = 8'h10;
    localparam logic [7:0]  CMD_RESET   = 8'hf0;
    localparam logic [7:0]  CMD_PROT    = 8'h60;
    localparam int          PROT_SEL_BIT = 6;

    // ====================================================================
    // autoselect codes; identity values are arbitrary
    localparam logic [15:0] MFR_CODE  = 16'h00a5;
    localparam logic [15:0] DEV_CODE  = 16'h005a;
    localparam logic [15:0] CODE_ONE  = 16'h0001;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [1:0]  ASEL_MFR  = 2'h0;
    localparam logic [1:0]  ASEL_DEV  = 2'h1;
    localparam logic [1:0]  ASEL_PROT = 2'h2;
    localparam logic [1:0]  ASEL_BRST = 2'h3;

    // ====================================================================
    // register map
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STAT     = 4'h4;
    localparam int          CTRL_BURST   = 0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [3:0] {
        CS_READ = 4'h0,
        CS_UL1  = 4'h1,
        CS_UL2  = 4'h2,
        CS_AUTO = 4'h3,
        CS_PROG = 4'h4,
        CS_ER0  = 4'h5,
        CS_ER1  = 4'h6,
        CS_ER2  = 4'h7
    } flp_cmd_t;

    // control pins and indications, all asynchronous to aclk
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic hv_reset;
        logic hv_a9;
        logic hv_oe;
        logic lockout;
    } flp_pins_t;

    localparam flp_pins_t PINS_RST = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: 1'b0};

    // request to the array program/erase engine
    typedef struct packed {
        logic            prog_req;
        logic            erase_req;
        logic [NSEC-1:0] erase_mask;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   data;
    } flp_op_t;
endpackage

// >>> design/flp_ctrl.sv
// flash command register, autoselect, sector protection and write control
// Overview of operation
// - output enable high places every data output in high impedance
// - word address decodes into nine sectors from 4K to 128K words
// - autoselect drives codes on the low data byte, chosen by two address bits
// - code 3 gives burst status; code 2 gives one for a protected sector
// - autoselect command enters autoselect without any high-voltage level
// - protected sectors refuse program and erase; unprotect re-enables both
// - all protection flags start unprotected
// - high voltage on reset pin selects protect/unprotect by normal writes
// - high voltage on A9 and output enable protects the addressed sector
// - high voltage on reset pin lets protected sectors be changed
// - removing that level protects the previously protected sectors again
// - bad value or order of command writes returns to array read, except in autoselect, which only the reset command or supply lockout leaves
// - address is taken when the later of chip and write enable falls
// - data is taken when the earlier of chip and write enable rises
// - after power-up the device reads the array with no command
// - program and erase need the unlock writes before the command
// - supply lockout ignores writes, idles command logic and resets it
// - a write needs chip and write enable low with output enable high
// - autoselect stays for any reads until the reset command or supply lockout
`timescale 1ns/1ns
`default_nettype none

// ========================================================================
// three-stage synchroniser; the output moves once stages two and three agree
module flp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] in_async,
    output logic      [W-1:0] out_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] f;
    } flp_sync_st_t;

    flp_sync_st_t q;
    flp_sync_st_t d;

    always_comb begin
        d    = q;
        d.s1 = in_async;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.f = q.s3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{s1: RST, s2: RST, s3: RST, f: RST};
        end else begin
            q <= d;
        end
    end

    assign out_sync = q.f;
endmodule // flp_sync

// ========================================================================
module flp_ctrl (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // flash pins and high-voltage indications
    input  wire flp_pkg::flp_pins_t       pins,
    input  wire logic [flp_pkg::AW-1:0]   addr,
    input  wire logic [flp_pkg::DW-1:0]   dq_i,
    output logic      [flp_pkg::DW-1:0]   dq_o,
    output logic                          dq_oe,
    // array side
    input  wire logic [flp_pkg::DW-1:0]   array_rdata,
    output flp_pkg::flp_op_t              op,
    // AXI4-Lite slave
    input  wire logic [3:0]               s_awaddr,
    input  wire logic                     s_awvalid,
    output logic                          s_awready,
    input  wire logic [31:0]              s_wdata,
    input  wire logic [3:0]               s_wstrb,
    input  wire logic                     s_wvalid,
    output logic                          s_wready,
    output logic [1:0]                    s_bresp,
    output logic                          s_bvalid,
    input  wire logic                     s_bready,
    input  wire logic [3:0]               s_araddr,
    input  wire logic                     s_arvalid,
    output logic                          s_arready,
    output logic [31:0]                   s_rdata,
    output logic [1:0]                    s_rresp,
    output logic                          s_rvalid,
    input  wire logic                     s_rready
);
    typedef struct packed {
        flp_pkg::flp_cmd_t          cmd;
        logic [flp_pkg::NSEC-1:0]   prot;
        logic                       burst;
        logic                       wr_act;
        logic [flp_pkg::AW-1:0]     wa;
        logic [flp_pkg::DW-1:0]     wd;
        logic [flp_pkg::DW-1:0]     dq_o;
        logic                       dq_oe;
        flp_pkg::flp_op_t           op;
        logic                       awready;
        logic                       wready;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       arready;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } flp_ctrl_st_t;

    flp_ctrl_st_t             q;
    flp_ctrl_st_t             d;
    flp_pkg::flp_pins_t       p;
    logic [flp_pkg::AW-1:0]   a_s;
    logic [flp_pkg::DW-1:0]   dq_s;

    // ====================================================================
    // pin synchronisers
    flp_sync #(.W(7), .RST(flp_pkg::PINS_RST)) u_sync_pins (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_async (pins),
        .out_sync (p)
    );
    flp_sync #(.W(flp_pkg::AW)) u_sync_addr (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_async (addr),
        .out_sync (a_s)
    );
    flp_sync #(.W(flp_pkg::DW)) u_sync_data (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .in_async (dq_i),
        .out_sync (dq_s)
    );

    // ====================================================================
    // sector decode of a word address
    function automatic logic [3:0] sec_of(input logic [flp_pkg::AW-1:0] a);
        if (a[18]) begin
            sec_of = a[17] ? 4'h8 : 4'h7;
        end else if (a[17] | a[16]) begin
            sec_of = 4'(2'(a[17:16]) + 4'h3);
        end else if (a[15] | a[14]) begin
            sec_of = 4'h3;
        end else if (a[13]) begin
            sec_of = a[12] ? 4'h2 : 4'h1;
        end else begin
            sec_of = 4'h0;
        end
    endfunction

    // ====================================================================
    // next state
    logic                       wr_now;
    logic                       wr_end;
    logic [flp_pkg::NSEC-1:0]   eff_prot;
    logic [3:0]                 wsec;
    logic [3:0]                 rsec;
    logic                       asel;
    logic                       ul1_ok;
    logic                       ul2_ok;
    logic [flp_pkg::NSEC-1:0]   mask;

    always_comb begin
        d        = q;
        d.op.prog_req  = 1'b0;
        d.op.erase_req = 1'b0;
        // hazard: OE low during WE/CE low must never count as a write
        wr_now   = ~p.ce_n & ~p.we_n & p.oe_n & ~p.lockout;
        wr_end   = q.wr_act & ~wr_now & ~p.lockout;
        eff_prot = q.prot & {flp_pkg::NSEC{~p.hv_reset}};
        wsec     = sec_of(q.wa);
        rsec     = sec_of(a_s);
        ul1_ok   = q.wa[10:0] == flp_pkg::UL1_ADDR;
        ul2_ok   = q.wa[10:0] == flp_pkg::UL2_ADDR;
        mask     = '0;
        d.wr_act = wr_now;
        if (wr_now & ~q.wr_act) begin
            d.wa = a_s;
        end
        if (wr_now) begin
            d.wd = dq_s;
        end
        if (wr_end) begin
            if (p.hv_a9 & p.hv_oe) begin
                d.prot[wsec] = 1'b1;
            end else if (p.hv_reset & (q.cmd != flp_pkg::CS_PROG) & (q.wd[7:0] == flp_pkg::CMD_PROT)) begin
                // unprotect clears every sector, so the host protects all first
                if (q.wa[flp_pkg::PROT_SEL_BIT]) begin
                    d.prot = '0;
                end else begin
                    d.prot[wsec] = 1'b1;
                end
            end else if ((q.cmd != flp_pkg::CS_PROG) & (q.wd[7:0] == flp_pkg::CMD_RESET)) begin
                d.cmd = flp_pkg::CS_READ;
            end else begin
                unique case (q.cmd)
                    flp_pkg::CS_READ: begin
                        if (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_UL1)) begin
                            d.cmd = flp_pkg::CS_UL1;
                        end
                    end
                    flp_pkg::CS_UL1: begin
                        d.cmd = (ul2_ok & (q.wd[7:0] == flp_pkg::CMD_UL2))
                                ? flp_pkg::CS_UL2 : flp_pkg::CS_READ;
                    end
                    flp_pkg::CS_UL2: begin
                        d.cmd = flp_pkg::CS_READ;
                        if (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_ASEL)) begin
                            d.cmd = flp_pkg::CS_AUTO;
                        end else if (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_PROG)) begin
                            d.cmd = flp_pkg::CS_PROG;
                        end else if (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_ERASE)) begin
                            d.cmd = flp_pkg::CS_ER0;
                        end
                    end
                    flp_pkg::CS_AUTO: begin
                        d.cmd = flp_pkg::CS_AUTO;
                    end
                    flp_pkg::CS_PROG: begin
                        d.cmd          = flp_pkg::CS_READ;
                        d.op.prog_req  = ~eff_prot[wsec];
                        d.op.addr      = q.wa;
                        d.op.data      = q.wd;
                    end
                    flp_pkg::CS_ER0: begin
                        d.cmd = (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_UL1))
                                ? flp_pkg::CS_ER1 : flp_pkg::CS_READ;
                    end
                    flp_pkg::CS_ER1: begin
                        d.cmd = (ul2_ok & (q.wd[7:0] == flp_pkg::CMD_UL2))
                                ? flp_pkg::CS_ER2 : flp_pkg::CS_READ;
                    end
                    flp_pkg::CS_ER2: begin
                        d.cmd = flp_pkg::CS_READ;
                        if (q.wd[7:0] == flp_pkg::CMD_SEC_ER) begin
                            mask = (9'h001 << wsec) & ~eff_prot;
                        end else if (ul1_ok & (q.wd[7:0] == flp_pkg::CMD_CHIP_ER)) begin
                            mask = ~eff_prot;
                        end
                        d.op.erase_req  = |mask;
                        d.op.erase_mask = mask;
                        d.op.addr       = q.wa;
                    end
                    default: begin
                        d.cmd = flp_pkg::CS_READ;
                    end
                endcase
            end
        end
        if (p.lockout) begin
            d.cmd    = flp_pkg::CS_READ;
            d.wr_act = 1'b0;
        end

        // read path
        asel    = p.hv_a9 | (q.cmd == flp_pkg::CS_AUTO);
        d.dq_oe = ~p.oe_n & ~p.ce_n & ~p.lockout;
        d.dq_o  = array_rdata;
        if (asel) begin
            unique case (a_s[1:0])
                flp_pkg::ASEL_MFR:  d.dq_o = flp_pkg::MFR_CODE;
                flp_pkg::ASEL_DEV:  d.dq_o = flp_pkg::DEV_CODE;
                flp_pkg::ASEL_PROT: d.dq_o = q.prot[rsec] ? flp_pkg::CODE_ONE
                                                          : flp_pkg::CODE_ZERO;
                flp_pkg::ASEL_BRST: d.dq_o = q.burst ? flp_pkg::CODE_ONE
                                                     : flp_pkg::CODE_ZERO;
            endcase
        end

        // ================================================================
        // register slave: address and data are taken together, one cycle after both are offered
        if (q.awready) begin
            d.awready = 1'b0;
            d.wready  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = flp_pkg::RESP_SLVERR;
            if (s_awaddr == flp_pkg::REG_CTRL) begin
                d.bresp = flp_pkg::RESP_OKAY;
                if (s_wstrb[0]) begin
                    d.burst = s_wdata[flp_pkg::CTRL_BURST];
                end
            end else if (s_awaddr == flp_pkg::REG_STAT) begin
                d.bresp = flp_pkg::RESP_OKAY;
            end
        end else if (s_awvalid & s_wvalid & ~q.bvalid) begin
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end
        if (q.bvalid & s_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.arready) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rdata   = '0;
            d.rresp   = flp_pkg::RESP_OKAY;
            if (s_araddr == flp_pkg::REG_CTRL) begin
                d.rdata[flp_pkg::CTRL_BURST] = q.burst;
            end else if (s_araddr == flp_pkg::REG_STAT) begin
                d.rdata[8:0]   = q.prot;
                d.rdata[9]     = asel;
                d.rdata[10]    = p.hv_reset;
                d.rdata[11]    = p.lockout;
                d.rdata[15:12] = q.cmd;
            end else begin
                d.rresp = flp_pkg::RESP_SLVERR;
            end
        end else if (s_arvalid & ~q.rvalid) begin
            d.arready = 1'b1;
        end
        if (q.rvalid & s_rready) begin
            d.rvalid = 1'b0;
        end
    end

    // power-up reset leaves array read and all sectors unprotected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dq_o      = q.dq_o;
    assign dq_oe     = q.dq_oe;
    assign op        = q.op;
    assign s_awready = q.awready;
    assign s_wready  = q.wready;
    assign s_bvalid  = q.bvalid;
    assign s_bresp   = q.bresp;
    assign s_arready = q.arready;
    assign s_rvalid  = q.rvalid;
    assign s_rdata   = q.rdata;
    assign s_rresp   = q.rresp;
endmodule // flp_ctrl

`default_nettype wire

// >>> testbench/flp_ctrl_monitor.sv
// port-level checker for the flash command, autoselect and protection block
`timescale 1ns/1ns
`default_nettype none
// ========================================================================
// checker
module flp_ctrl_monitor (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire flp_pkg::flp_pins_t     pins,
    input wire logic [flp_pkg::AW-1:0] addr,
    input wire logic [flp_pkg::DW-1:0] dq_o,
    input wire logic                   dq_oe,
    input wire flp_pkg::flp_op_t       op,
    input wire logic                   s_awvalid,
    input wire logic                   s_awready,
    input wire logic                   s_bvalid,
    input wire logic                   s_arvalid,
    input wire logic                   s_arready,
    input wire logic [3:0]             s_araddr,
    input wire logic                   s_rvalid,
    input wire logic [31:0]            s_rdata,
    input wire logic [1:0]             s_rresp
);
    // cycles since the pins last showed a write, saturating
    logic [7:0] wr_age_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) wr_age_q <= 8'hff;
        else if (!pins.ce_n && !pins.we_n && pins.oe_n && !pins.lockout) wr_age_q <= 8'h00;
        else if (wr_age_q != 8'hff) wr_age_q <= wr_age_q + 8'h01;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_oe_tristate: assert property (pins.oe_n [*8] |-> !dq_oe)
        else $error("data driven with output enable high");
    a_lockout_quiet: assert property (pins.lockout [*8] |-> !dq_oe && !op.prog_req && !op.erase_req)
        else $error("activity during supply lockout");
    a_op_after_write: assert property (op.prog_req || op.erase_req |-> wr_age_q <= 8'd12)
        else $error("array request without a write");
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !dq_oe && !op.prog_req && !op.erase_req)
        else $error("outputs active after reset");
    a_asel_pin_code: assert property ((pins.hv_a9 && !pins.ce_n && !pins.oe_n && !pins.lockout
        && addr[1:0] == 2'h0) [*8] |-> dq_oe && dq_o == flp_pkg::MFR_CODE)
        else $error("wrong pin autoselect code");
    a_pulse_single: assert property (op.prog_req |=> !op.prog_req && !op.erase_req)
        else $error("program request too long");
    a_write_answer: assert property (s_awvalid && s_awready |=> s_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read response late");
    a_unmapped_read: assert property (s_arvalid && s_arready && s_araddr[3]
        |=> s_rresp == flp_pkg::RESP_SLVERR && s_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // flp_ctrl_monitor

bind flp_ctrl flp_ctrl_monitor u_mon (.*);
`default_nettype wire

// >>> testbench/flp_host.sv
// host bus model that drives the flash control pins, address and data
`timescale 1ns/1ns
`default_nettype none
// ========================================================================
// host
module flp_host (
    input  wire logic                   aclk,
    output flp_pkg::flp_pins_t          pins,
    output logic [flp_pkg::AW-1:0]      addr,
    output logic [flp_pkg::DW-1:0]      dq_h,
    output logic                        rd_stb
);
    initial begin
        pins = flp_pkg::PINS_RST;
        addr = '0;
        dq_h = '0;
        rd_stb = 1'b0;
    end

    // each level is held six clocks, past the synchroniser depth
    task automatic ph(input logic c, input logic w, input logic o, input logic [18:0] a, input logic [15:0] d);
        @(posedge aclk);
        pins.ce_n <= c;
        pins.we_n <= w;
        pins.oe_n <= o;
        addr <= a;
        dq_h <= d;
        repeat (5) @(posedge aclk);
    endtask

    // write enable falls before chip enable; address and data are junk outside their windows
    task automatic wr(input logic [18:0] a, input logic [15:0] d, input logic o = 1'b1);
        ph(1'b1, 1'b0, o, a, ~d);
        ph(1'b0, 1'b0, o, a, ~d);
        ph(1'b0, 1'b0, o, ~a, d);
        ph(1'b0, 1'b1, o, ~a, d);
        ph(1'b1, 1'b1, 1'b1, ~a, ~d);
    endtask

    task automatic rd(input logic [18:0] a);
        ph(1'b0, 1'b1, 1'b0, a, 16'hffff);
        repeat (2) @(posedge aclk);
        rd_stb <= 1'b1;
        @(posedge aclk);
        rd_stb <= 1'b0;
        ph(1'b1, 1'b1, 1'b1, ~a, 16'h0000);
    endtask

    task automatic lvl(input logic [3:0] v);
        @(posedge aclk);
        {pins.hv_reset, pins.hv_a9, pins.hv_oe, pins.lockout} <= v;
        repeat (8) @(posedge aclk);
    endtask
endmodule // flp_host
`default_nettype wire

// >>> testbench/flp_ctrl_tb.sv
// self-checking testbench for the flash command, autoselect and protection block
`timescale 1ns/1ns
`default_nettype none
module flp_ctrl_tb;
    localparam logic [18:0] U1 = 19'(flp_pkg::UL1_ADDR);
    localparam logic [18:0] U2 = 19'(flp_pkg::UL2_ADDR);
    logic aclk = 1'b0;
    logic aresetn;
    flp_pkg::flp_pins_t pins;
    flp_pkg::flp_op_t op;
    logic [18:0] addr;
    logic [15:0] dq_h, dq_o, ard;
    logic dq_oe, rd_stb, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [3:0] s_awaddr, s_araddr, s_wstrb;
    logic [31:0] s_wdata, s_rdata;
    logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic [1:0] s_bresp, s_rresp;
    logic [65:0] q[$];
    int error_cnt = 0;
    int num_checks = 0;
    logic [19:0] base [10] = '{20'h0, 20'h2000, 20'h3000, 20'h4000, 20'h10000, 20'h20000, 20'h30000,
        20'h40000, 20'h60000, 20'h80000};
    string nm [4] = '{"op", "axi_read", "flash_read", "axi_resp"};
    always #5 aclk = ~aclk;

    flp_host u_host (.*);
    flp_ctrl u_dut (.*, .dq_i(dq_oe ? dq_o : dq_h), .array_rdata(ard));

    // ====================================================================
    // result watcher
    task automatic chk(input logic [1:0] k, input logic [63:0] v);
        logic [65:0] e;
        num_checks++;
        e = (q.size() != 0) ? q.pop_front() : '1;
        if (e !== {k, v}) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm[k], e, {k, v});
        end
    endtask

    always @(posedge aclk) begin
        if (op.prog_req === 1'b1) chk(2'd0, 64'({2'b10, 9'h0, op.addr, op.data}));
        if (op.erase_req === 1'b1) chk(2'd0, 64'({2'b01, op.erase_mask, 35'h0}));
        if ((s_rvalid && s_rready) === 1'b1) chk(2'd1, 64'({s_rresp, s_rdata}));
        if ((s_bvalid && s_bready) === 1'b1) chk(2'd3, 64'(s_bresp));
        if (rd_stb) chk(2'd2, 64'({dq_oe, dq_oe ? dq_o : 16'h0}));
    end

    // ====================================================================
    // drivers
    task automatic finish_test();
        if (q.size() != 0) error_cnt++;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic axi(input bit w, input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        q.push_back(w ? {2'd3, 64'(r)} : {2'd1, 64'({r, d})});
        @(posedge aclk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= d;
        s_wstrb <= {3'($urandom), 1'b1};
        s_awvalid <= w;
        s_wvalid <= w;
        s_bready <= w;
        s_arvalid <= !w;
        s_rready <= !w;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_arready) s_arvalid <= 1'b0;
            if (w ? s_bvalid : s_rvalid) break;
        end
        s_bready <= 1'b0;
        s_rready <= 1'b0;
        if (n == 40) begin
            error_cnt++;
            finish_test();
        end
    endtask

    task automatic cmd(input logic [18:0] a, input logic [7:0] c);
        u_host.wr(a, {8'h00, c});
    endtask
    task automatic unl();
        cmd(U1, flp_pkg::CMD_UL1);
        cmd(U2, flp_pkg::CMD_UL2);
    endtask
    task automatic prog(input logic [18:0] a, input logic [15:0] d, input bit hit);
        unl();
        cmd(U1, flp_pkg::CMD_PROG);
        if (hit) q.push_back({2'd0, 64'({2'b10, 9'h0, a, d})});
        u_host.wr(a, d);
    endtask
    task automatic erase(input logic [18:0] a, input logic [7:0] c, input logic [8:0] m, input bit hit);
        unl();
        cmd(U1, flp_pkg::CMD_ERASE);
        unl();
        if (hit) q.push_back({2'd0, 64'({2'b01, m, 35'h0})});
        cmd(a, c);
    endtask
    task automatic rdq(input logic [18:0] a, input logic oe, input logic [15:0] v);
        q.push_back({2'd2, 64'({oe, v})});
        u_host.rd(a);
    endtask

    // ====================================================================
    // main sequence
    initial begin
        logic [18:0] a;
        logic [15:0] d;
        int s;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, ard} <= '0;
        void'($urandom(87));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, flp_pkg::REG_STAT, 32'h0, flp_pkg::RESP_OKAY);
        axi(1'b0, 4'h8, 32'h0, flp_pkg::RESP_SLVERR);
        axi(1'b1, 4'hc, 32'h1, flp_pkg::RESP_SLVERR);
        d = 16'($urandom);
        ard <= d;
        rdq(19'($urandom), 1'b1, d);
        a = 19'($urandom);
        d = 16'($urandom);
        prog(a, d, 1'b1);
        for (s = 0; s < 9; s++) begin
            erase(19'(base[s] + 20'($urandom % (base[s+1] - base[s]))), flp_pkg::CMD_SEC_ER, 9'(1 << s), 1'b1);
        end
        erase(U1, flp_pkg::CMD_CHIP_ER, 9'h1ff, 1'b1);
        cmd(U1, flp_pkg::CMD_UL1);
        cmd(U2, 8'h56);
        cmd(U1, flp_pkg::CMD_PROG);
        u_host.wr(a, d);
        unl();
        cmd(U1, flp_pkg::CMD_PROG);
        u_host.wr(~a, ~d, 1'b0);
        q.push_back({2'd0, 64'({2'b10, 9'h0, a, d})});
        u_host.wr(a, d);
        unl();
        cmd(U1, flp_pkg::CMD_ASEL);
        rdq({17'($urandom), 2'h0}, 1'b1, flp_pkg::MFR_CODE);
        rdq({17'($urandom), 2'h1}, 1'b1, flp_pkg::DEV_CODE);
        rdq({17'($urandom), 2'h2}, 1'b1, flp_pkg::CODE_ZERO);
        rdq({17'($urandom), 2'h3}, 1'b1, flp_pkg::CODE_ZERO);
        axi(1'b1, flp_pkg::REG_CTRL, 32'h1, flp_pkg::RESP_OKAY);
        rdq({17'($urandom), 2'h3}, 1'b1, flp_pkg::CODE_ONE);
        unl();
        rdq({17'($urandom), 2'h0}, 1'b1, flp_pkg::MFR_CODE);
        cmd(19'h0, flp_pkg::CMD_RESET);
        ard <= ~d;
        rdq(a, 1'b1, ~d);
        axi(1'b1, flp_pkg::REG_CTRL, 32'h0, flp_pkg::RESP_OKAY);
        // address bit 6 low: the write protects sector 5
        u_host.lvl(4'b1000);
        cmd(19'h23b25, flp_pkg::CMD_PROT);
        axi(1'b0, flp_pkg::REG_STAT, 32'h420, flp_pkg::RESP_OKAY);
        u_host.lvl(4'b0000);
        axi(1'b0, flp_pkg::REG_STAT, 32'h20, flp_pkg::RESP_OKAY);
        u_host.lvl(4'b0100);
        rdq(19'h23b26, 1'b1, flp_pkg::CODE_ONE);
        rdq(19'h13b26, 1'b1, flp_pkg::CODE_ZERO);
        rdq(19'h13b24, 1'b1, flp_pkg::MFR_CODE);
        u_host.lvl(4'b0000);
        prog(19'h23b25, d, 1'b0);
        prog(19'h13b25, d, 1'b1);
        erase(19'h23b25, flp_pkg::CMD_SEC_ER, 9'h0, 1'b0);
        erase(U1, flp_pkg::CMD_CHIP_ER, 9'h1df, 1'b1);
        u_host.lvl(4'b1000);
        prog(19'h23b25, d, 1'b1);
        u_host.lvl(4'b0000);
        prog(19'h23b25, ~d, 1'b0);
        axi(1'b0, flp_pkg::REG_STAT, 32'h20, flp_pkg::RESP_OKAY);
        u_host.lvl(4'b0110);
        u_host.wr(19'h61234, 16'h0000);
        u_host.lvl(4'b0000);
        axi(1'b0, flp_pkg::REG_STAT, 32'h120, flp_pkg::RESP_OKAY);
        u_host.lvl(4'b1000);
        for (s = 0; s < 9; s++) cmd(19'(base[s]), flp_pkg::CMD_PROT);
        cmd(19'h00040, flp_pkg::CMD_PROT);
        u_host.lvl(4'b0000);
        axi(1'b0, flp_pkg::REG_STAT, 32'h0, flp_pkg::RESP_OKAY);
        u_host.lvl(4'b0001);
        rdq(a, 1'b0, 16'h0);
        axi(1'b0, flp_pkg::REG_STAT, 32'h800, flp_pkg::RESP_OKAY);
        prog(a, d, 1'b0);
        u_host.lvl(4'b0000);
        unl();
        u_host.lvl(4'b0001);
        u_host.lvl(4'b0000);
        cmd(U1, flp_pkg::CMD_PROG);
        u_host.wr(a, d);
        prog(a, d, 1'b1);
        finish_test();
    end
endmodule // flp_ctrl_tb
`default_nettype wire
